// *** logic/phy_regs_pkg.sv ***
// constants for the 10 Mbit/s control and quick status registers
// assumes management frames arrive on the mdc/mdio pins
package phy_regs_pkg;

  // ----------------------------------------
  // frame format
  // ----------------------------------------
  localparam logic [4:0] PHY_ADDR = 5'h10;
  localparam logic [4:0] REG_TEN_CTRL = 5'h1E;
  localparam logic [4:0] REG_QSTAT = 5'h1F;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [4:0] HDR_BITS = 5'h0D;
  localparam logic [4:0] TA_BITS = 5'h02;
  localparam logic [4:0] DATA_BITS = 5'h10;

  // ----------------------------------------
  // ten_meg_control fields
  // ----------------------------------------
  localparam int TC_TONE = 15;
  localparam int TC_PWR = 14;
  localparam int TC_JAB = 13;
  localparam int TC_ELT = 6;
  localparam int TC_HBT = 5;
  localparam int TC_LLE = 4;
  localparam int TC_POL = 3;
  localparam int TC_SER = 1;
  localparam int TC_NLP = 0;
  localparam logic [15:0] TC_WMASK = 16'hE07F;
  localparam logic [15:0] TC_RESET = 16'h0000;

  // ----------------------------------------
  // quick_status fields
  // ----------------------------------------
  localparam int QS_CFG = 7;
  localparam int QS_MASK = 6;
  localparam logic QS_CFG_RESET = 1'b0;
  localparam logic QS_MASK_RESET = 1'b0;
  localparam logic [2:0] AN_LO_RESET = 3'h7;
  localparam logic [2:0] AN_HI_RESET = 3'h0;

  typedef enum logic [1:0] {st_idle, st_hdr, st_ta, st_data} mdio_state_t;

endpackage : phy_regs_pkg

// *** logic/mgmt_if.sv ***
// register access strobes between frame engine and register bank
// assumes one clock shared by both ends
`timescale 1ns/10ps
`default_nettype none
interface mgmt_if;
  logic rd_stb;
  logic wr_stb;
  logic [4:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport engine (output rd_stb, output wr_stb, output addr, output wdata, input rdata);
  modport regs (input rd_stb, input wr_stb, input addr, input wdata, output rdata);
endinterface : mgmt_if
`default_nettype wire

// *** logic/mdio_frame.sv ***
// management frame engine: samples mdc/mdio, issues register strobes
// assumes mdc well below half of clk
`timescale 1ns/10ps
`default_nettype none
module mdio_frame
  import phy_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n,
  mgmt_if.engine bus
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic mdc_s1_r, mdc_s2_r, mdc_s3_r, din_s1_r, din_s2_r;
  logic rise;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mdc_s1_r <= 1'b0;
      mdc_s2_r <= 1'b0;
      mdc_s3_r <= 1'b0;
      din_s1_r <= 1'b1;
      din_s2_r <= 1'b1;
    end else begin
      mdc_s1_r <= mdc;
      mdc_s2_r <= mdc_s1_r;
      mdc_s3_r <= mdc_s2_r;
      din_s1_r <= mdio_in;
      din_s2_r <= din_s1_r;
    end
  end

  assign rise = mdc_s2_r & ~mdc_s3_r;

  // ----------------------------------------
  // frame sequencer
  // ----------------------------------------
  mdio_state_t state_r;
  logic [4:0] cnt_r;
  logic [15:0] in_sh_r, out_sh_r;
  logic hit_r, rd_r;
  logic [12:0] hdr;

  assign hdr = {in_sh_r[11:0], din_s2_r};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= st_idle;
      cnt_r <= 5'h00;
      in_sh_r <= 16'h0000;
      hit_r <= 1'b0;
      rd_r <= 1'b0;
      bus.addr <= 5'h00;
    end else if (rise) begin
      in_sh_r <= {in_sh_r[14:0], din_s2_r};
      cnt_r <= cnt_r + 5'h01;
      unique case (state_r)
        st_idle: begin
          cnt_r <= 5'h00;
          if (!din_s2_r) state_r <= st_hdr;
        end
        st_hdr: begin
          if (cnt_r == HDR_BITS - 5'h01) begin
            // start 01, opcode, phy address MSB first
            hit_r <= hdr[12] && (hdr[9:5] == PHY_ADDR) &&
                     (hdr[11:10] == OP_READ || hdr[11:10] == OP_WRITE);
            rd_r <= (hdr[11:10] == OP_READ);
            bus.addr <= hdr[4:0];
            cnt_r <= 5'h00;
            state_r <= st_ta;
          end
        end
        st_ta: begin
          if (cnt_r == TA_BITS - 5'h01) begin
            cnt_r <= 5'h00;
            state_r <= st_data;
          end
        end
        st_data: begin
          if (cnt_r == DATA_BITS - 5'h01) state_r <= st_idle;
        end
      endcase
    end
  end

  // ----------------------------------------
  // strobes and data
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.rd_stb <= 1'b0;
      bus.wr_stb <= 1'b0;
      bus.wdata <= 16'h0000;
    end else begin
      bus.rd_stb <= rise && state_r == st_hdr && cnt_r == HDR_BITS - 5'h01 &&
                    hdr[12] && hdr[9:5] == PHY_ADDR && hdr[11:10] == OP_READ;
      bus.wr_stb <= rise && state_r == st_data && cnt_r == DATA_BITS - 5'h01 &&
                    hit_r && !rd_r;
      if (rise && state_r == st_data && cnt_r == DATA_BITS - 5'h01)
        bus.wdata <= {in_sh_r[14:0], din_s2_r};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_sh_r <= 16'h0000;
    end else if (rise && state_r == st_ta && cnt_r == 5'h00) begin
      out_sh_r <= bus.rdata;
    end else if (rise && state_r == st_data) begin
      out_sh_r <= {out_sh_r[14:0], 1'b0};
    end
  end

  // released in first turnaround bit, low in second, then bit 15 first
  assign mdio_out = (state_r == st_data) ? out_sh_r[15] : 1'b0;
  assign mdio_oe_n = ~(hit_r && rd_r &&
                       ((state_r == st_ta && cnt_r == 5'h01) || state_r == st_data));

endmodule : mdio_frame
`default_nettype wire

// *** logic/phy_ten_meg_ctrl_quick_status.sv ***
// 10 Mbit/s control and quick status registers of the embedded phy
// assumes event inputs come from phy logic on clk, one-cycle pulses
//
// How it works
// - test bit sends 10 MHz ones when powered
// - power-hold bit keeps 10M logic on link
// - jabber-disable bit turns off receive jabber
// - enhanced link test is bit OR pin
// - heartbeat bit acts only at 10M
// - long-line bit lowers squelch at 10M
// - polarity reversal flagged at 10M, corrected unless disabled
// - serial-select bit ignored at 100M
// - no-link-pulse bit ignored at 100M
// - receive error latched at 100M until read
// - bit 14: false carrier or link change
// - remote fault latched until read
// - lock loss or jabber latched until read
// - link valid latches low until read
// - partner pause shown live
// - speed flag: 1 is 100M
// - duplex flag: 1 is full
// - config 1: irq only on link change
// - mask high blocks every interrupt
// - lowest autoneg state since last read
// - highest autoneg state since last read
// - frames: 01 start, opcodes, MSB first
// - answer only phy address 10h
`timescale 1ns/10ps
`default_nettype none
module phy_ten_meg_ctrl_quick_status
  import phy_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n,
  input wire logic enhanced_link_pin,
  input wire logic ten_powered,
  input wire logic link_up,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic partner_pause,
  input wire logic polarity_reversed,
  input wire logic rx_error_evt,
  input wire logic false_carrier_evt,
  input wire logic remote_fault_evt,
  input wire logic unlock_evt,
  input wire logic jabber_evt,
  input wire logic [2:0] an_state,
  output logic test_tone_on,
  output logic power_hold_on,
  output logic jabber_func_en,
  output logic enhanced_link_test,
  output logic heartbeat_on,
  output logic long_line_on,
  output logic polarity_status,
  output logic polarity_correct,
  output logic serial_mode,
  output logic no_link_pulse_on,
  output logic status_irq
);

  // ----------------------------------------
  // frame engine
  // ----------------------------------------
  mgmt_if bus ();

  mdio_frame u_frame (
    .clk(clk),
    .rst_n(rst_n),
    .mdc(mdc),
    .mdio_in(mdio_in),
    .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n),
    .bus(bus.engine)
  );

  logic tc_wr, qs_wr, tc_rd, qs_rd;

  assign tc_wr = bus.wr_stb && bus.addr == REG_TEN_CTRL;
  assign qs_wr = bus.wr_stb && bus.addr == REG_QSTAT;
  assign tc_rd = bus.rd_stb && bus.addr == REG_TEN_CTRL;
  assign qs_rd = bus.rd_stb && bus.addr == REG_QSTAT;

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  logic elt_s1_r, elt_s2_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      elt_s1_r <= 1'b0;
      elt_s2_r <= 1'b0;
    end else begin
      elt_s1_r <= enhanced_link_pin;
      elt_s2_r <= elt_s1_r;
    end
  end

  // ----------------------------------------
  // ten_meg_control register
  // ----------------------------------------
  logic [15:0] ten_ctrl_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ten_ctrl_r <= TC_RESET;
    end else if (tc_wr) begin
      ten_ctrl_r <= bus.wdata & TC_WMASK;
    end
  end

  // ----------------------------------------
  // quick_status control bits
  // ----------------------------------------
  logic irq_config_r, irq_mask_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_config_r <= QS_CFG_RESET;
      irq_mask_r <= QS_MASK_RESET;
    end else if (qs_wr) begin
      irq_config_r <= bus.wdata[QS_CFG];
      irq_mask_r <= bus.wdata[QS_MASK];
    end
  end

  // ----------------------------------------
  // latched status flags, set wins over read
  // ----------------------------------------
  logic rx_err_flag_r;
  logic false_carrier_flag_r;
  logic link_change_flag_r;
  logic remote_fault_flag_r;
  logic lock_jabber_flag_r;
  logic link_valid_flag_r;
  logic link_prev_r;
  logic link_change;
  logic lock_jabber_evt;

  assign link_change = link_up ^ link_prev_r;
  assign lock_jabber_evt = speed_100 ? unlock_evt
                                     : (jabber_evt & ~ten_ctrl_r[TC_JAB]);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_prev_r <= 1'b0;
    end else begin
      link_prev_r <= link_up;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_err_flag_r <= 1'b0;
    end else if (rx_error_evt && speed_100) begin
      rx_err_flag_r <= 1'b1;
    end else if (qs_rd) begin
      rx_err_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      false_carrier_flag_r <= 1'b0;
    end else if (false_carrier_evt && speed_100) begin
      false_carrier_flag_r <= 1'b1;
    end else if (qs_rd) begin
      false_carrier_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_change_flag_r <= 1'b0;
    end else if (link_change) begin
      link_change_flag_r <= 1'b1;
    end else if (qs_rd) begin
      link_change_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      remote_fault_flag_r <= 1'b0;
    end else if (remote_fault_evt) begin
      remote_fault_flag_r <= 1'b1;
    end else if (qs_rd) begin
      remote_fault_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_jabber_flag_r <= 1'b0;
    end else if (lock_jabber_evt) begin
      lock_jabber_flag_r <= 1'b1;
    end else if (qs_rd) begin
      lock_jabber_flag_r <= 1'b0;
    end
  end

  // failure wins over the reload that a read makes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_valid_flag_r <= 1'b0;
    end else if (!link_up) begin
      link_valid_flag_r <= 1'b0;
    end else if (qs_rd) begin
      link_valid_flag_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // autonegotiation lowest and highest state
  // ----------------------------------------
  logic [2:0] an_lowest_state_r, an_highest_state_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      an_lowest_state_r <= AN_LO_RESET;
    end else if (qs_rd) begin
      an_lowest_state_r <= an_state;
    end else if (an_state < an_lowest_state_r) begin
      an_lowest_state_r <= an_state;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      an_highest_state_r <= AN_HI_RESET;
    end else if (qs_rd) begin
      an_highest_state_r <= an_state;
    end else if (an_state > an_highest_state_r) begin
      an_highest_state_r <= an_state;
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [15:0] qs_word, tc_word;
  logic flag14;

  assign flag14 = irq_config_r ? link_change_flag_r : false_carrier_flag_r;

  assign qs_word = {rx_err_flag_r,
                    flag14,
                    remote_fault_flag_r,
                    lock_jabber_flag_r,
                    link_valid_flag_r,
                    partner_pause,
                    speed_100,
                    full_duplex,
                    irq_config_r,
                    irq_mask_r,
                    an_lowest_state_r,
                    an_highest_state_r};

  assign tc_word = ten_ctrl_r;

  // snapshot taken at the same edge that clears the flags
  logic [15:0] rdata_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 16'h0000;
    end else if (qs_rd) begin
      rdata_r <= qs_word;
    end else if (tc_rd) begin
      rdata_r <= tc_word;
    end else if (bus.rd_stb) begin
      rdata_r <= 16'h0000;
    end
  end

  assign bus.rdata = rdata_r;

  // ----------------------------------------
  // interrupt
  // ----------------------------------------
  logic irq_nxt;

  always_comb begin
    if (irq_mask_r) begin
      irq_nxt = 1'b0;
    end else if (irq_config_r) begin
      irq_nxt = link_change_flag_r;
    end else begin
      irq_nxt = rx_err_flag_r | false_carrier_flag_r | remote_fault_flag_r |
                lock_jabber_flag_r | ~link_valid_flag_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_irq <= 1'b0;
    end else begin
      status_irq <= irq_nxt;
    end
  end

  // ----------------------------------------
  // control outputs to the 10M transceiver
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      test_tone_on <= 1'b0;
      power_hold_on <= 1'b0;
      jabber_func_en <= 1'b1;
      enhanced_link_test <= 1'b0;
    end else begin
      test_tone_on <= ten_ctrl_r[TC_TONE] & ten_powered;
      power_hold_on <= ten_ctrl_r[TC_PWR] & link_up;
      jabber_func_en <= ~ten_ctrl_r[TC_JAB];
      enhanced_link_test <= ten_ctrl_r[TC_ELT] | elt_s2_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      heartbeat_on <= 1'b0;
      long_line_on <= 1'b0;
      serial_mode <= 1'b0;
      no_link_pulse_on <= 1'b0;
    end else begin
      heartbeat_on <= ten_ctrl_r[TC_HBT] & ~speed_100;
      long_line_on <= ten_ctrl_r[TC_LLE] & ~speed_100;
      serial_mode <= ten_ctrl_r[TC_SER] & ~speed_100;
      no_link_pulse_on <= ten_ctrl_r[TC_NLP] & ~speed_100;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      polarity_status <= 1'b0;
      polarity_correct <= 1'b0;
    end else begin
      polarity_status <= polarity_reversed & ~speed_100;
      polarity_correct <= polarity_reversed & ~speed_100 &
                          ~ten_ctrl_r[TC_POL];
    end
  end

endmodule : phy_ten_meg_ctrl_quick_status
`default_nettype wire

// *** bench/phy_qstat_sva.sv ***
// assertions on the ports of the 10M control and quick status block
// assumes one clk domain and an async active-low rst_n
`timescale 1ns/10ps
`default_nettype none
module phy_qstat_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mdc,
  input wire logic mdio_out,
  input wire logic mdio_oe_n,
  input wire logic enhanced_link_pin,
  input wire logic ten_powered,
  input wire logic link_up,
  input wire logic speed_100,
  input wire logic polarity_reversed,
  input wire logic test_tone_on,
  input wire logic power_hold_on,
  input wire logic enhanced_link_test,
  input wire logic heartbeat_on,
  input wire logic long_line_on,
  input wire logic serial_mode,
  input wire logic no_link_pulse_on,
  input wire logic polarity_status,
  input wire logic polarity_correct,
  input wire logic status_irq
);
  logic mdc_r;
  logic [4:0] rise_cnt_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // mdc rises counted while the block drives mdio
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) mdc_r <= 1'b0;
    else mdc_r <= mdc;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rise_cnt_r <= 5'h00;
    else if (mdio_oe_n) rise_cnt_r <= 5'h00;
    else if (mdc && !mdc_r) rise_cnt_r <= rise_cnt_r + 5'h01;
  end
  property p_tone; $fell(ten_powered) |=> !test_tone_on; endproperty
  a_tone: assert property (p_tone) else $error("tone on while unpowered");
  property p_hold; $fell(link_up) |=> !power_hold_on; endproperty
  a_hold: assert property (p_hold) else $error("power hold without link");
  property p_ten_only;
    speed_100 |=> !(heartbeat_on || long_line_on || serial_mode || no_link_pulse_on);
  endproperty
  a_ten_only: assert property (p_ten_only) else $error("10M option at 100M");
  property p_pol; (polarity_reversed && !speed_100) |=> polarity_status; endproperty
  a_pol: assert property (p_pol) else $error("reversal not flagged");
  property p_pol_fix; polarity_correct |-> polarity_status; endproperty
  a_pol_fix: assert property (p_pol_fix) else $error("correction without flag");
  property p_elt; enhanced_link_pin [*4] |=> enhanced_link_test; endproperty
  a_elt: assert property (p_elt) else $error("pin not ored in");
  property p_ta; $fell(mdio_oe_n) |-> !mdio_out ##1 !mdio_out; endproperty
  a_ta: assert property (p_ta) else $error("turnaround not zero");
  property p_data_len; $rose(mdio_oe_n) |-> rise_cnt_r == 5'h11; endproperty
  a_data_len: assert property (p_data_len) else $error("read drive length");
  property p_irq_rst; $rose(rst_n) |-> ##[1:2] status_irq; endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("no irq on link low");
  c_read: cover property ($rose(mdio_oe_n));
  c_irq: cover property ($rose(status_irq));
  c_fix: cover property (polarity_correct);
endmodule : phy_qstat_sva
bind phy_ten_meg_ctrl_quick_status phy_qstat_sva u_phy_qstat_sva (
  .clk(clk), .rst_n(rst_n), .mdc(mdc), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
  .enhanced_link_pin(enhanced_link_pin), .ten_powered(ten_powered), .link_up(link_up),
  .speed_100(speed_100), .polarity_reversed(polarity_reversed), .test_tone_on(test_tone_on),
  .power_hold_on(power_hold_on), .enhanced_link_test(enhanced_link_test),
  .heartbeat_on(heartbeat_on), .long_line_on(long_line_on), .serial_mode(serial_mode),
  .no_link_pulse_on(no_link_pulse_on), .polarity_status(polarity_status),
  .polarity_correct(polarity_correct), .status_irq(status_irq)
);
`default_nettype wire

// *** bench/mdio_station.sv ***
// station management model: mdc and frames on mdio, pull-up when released
// assumes the block samples mdc through a synchroniser on clk
`timescale 1ns/10ps
`default_nettype none
module mdio_station
  import phy_regs_pkg::*;
(
  input wire logic clk,
  input wire logic mdio_out,
  input wire logic mdio_oe_n,
  output logic mdc,
  output logic mdio_in,
  output logic rd_done,
  output logic [15:0] rd_word
);
  logic drv_en = 1'b0;
  logic drv_val = 1'b1;
  // line level, pulled up when nobody drives
  assign mdio_in = !mdio_oe_n ? mdio_out : (drv_en ? drv_val : 1'b1);
  initial begin
    mdc = 1'b0;
    rd_done = 1'b0;
    rd_word = 16'h0000;
  end
  // one bit: data set while mdc low, sampled at the rise
  task automatic bit_cyc(input logic en, input logic val, output logic smp);
    @(negedge clk);
    mdc = 1'b0;
    drv_en = en;
    drv_val = val;
    repeat (5) @(negedge clk);
    mdc = 1'b1;
    smp = mdio_in;
    repeat (4) @(negedge clk);
  endtask : bit_cyc
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [17:0] hdr;
    logic s;
    hdr = {4'hF, 2'h1, op, phy, ra};
    for (int i = 17; i >= 0; i--) bit_cyc(1'b1, hdr[i], s);
    bit_cyc(op == OP_WRITE, 1'b1, s);
    bit_cyc(op == OP_WRITE, 1'b0, s);
    for (int i = 15; i >= 0; i--) begin
      bit_cyc(op == OP_WRITE, wd[i], s);
      rd[i] = s;
    end
    @(negedge clk);
    mdc = 1'b0;
    drv_en = 1'b0;
    if (op == OP_READ) begin
      rd_word = rd;
      rd_done = 1'b1;
      @(negedge clk);
      rd_done = 1'b0;
    end
  endtask : xfer
endmodule : mdio_station
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the 10M control and quick status block
// assumes mdio_station plays the management station
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top
  import phy_regs_pkg::*;
;
  logic clk, rst_n, elt_pin, ten_powered, link_up, speed_100, full_duplex, partner_pause;
  logic pol_rev, mdc, mdio_in, mdio_out, mdio_oe_n, rd_done, status_irq;
  logic test_tone_on, power_hold_on, jabber_func_en, enhanced_link_test, polarity_status;
  logic heartbeat_on, long_line_on, polarity_correct, serial_mode, no_link_pulse_on;
  logic [4:0] ev;
  logic [2:0] an_state;
  logic [15:0] rd_word, rd, w, exp_w;
  logic [15:0] exp_q[$];
  int mismatches = 0;
  int checked = 0;
  wire logic [3:0] ten_out = {heartbeat_on, long_line_on, serial_mode, no_link_pulse_on};
  phy_ten_meg_ctrl_quick_status u_phy_ten_meg_ctrl_quick_status (
    .clk(clk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n), .enhanced_link_pin(elt_pin), .ten_powered(ten_powered),
    .link_up(link_up), .speed_100(speed_100), .full_duplex(full_duplex),
    .partner_pause(partner_pause), .polarity_reversed(pol_rev), .rx_error_evt(ev[4]),
    .false_carrier_evt(ev[3]), .remote_fault_evt(ev[2]), .unlock_evt(ev[1]),
    .jabber_evt(ev[0]), .an_state(an_state), .test_tone_on(test_tone_on),
    .power_hold_on(power_hold_on), .jabber_func_en(jabber_func_en),
    .enhanced_link_test(enhanced_link_test), .heartbeat_on(heartbeat_on),
    .long_line_on(long_line_on), .polarity_status(polarity_status),
    .polarity_correct(polarity_correct), .serial_mode(serial_mode),
    .no_link_pulse_on(no_link_pulse_on), .status_irq(status_irq)
  );
  mdio_station u_mdio_station (.clk(clk), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
    .mdc(mdc), .mdio_in(mdio_in), .rd_done(rd_done), .rd_word(rd_word));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  function automatic logic [15:0] qs(input logic [3:0] f, input logic lv, input logic [1:0] cm,
                                     input logic [2:0] lo, input logic [2:0] hi);
    qs = {f, lv, partner_pause, speed_100, full_duplex, cm, lo, hi};
  endfunction : qs
  task automatic rdp(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] e);
    exp_q.push_back(e);
    u_mdio_station.xfer(OP_READ, phy, ra, 16'h0000, rd);
  endtask : rdp
  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    u_mdio_station.xfer(OP_WRITE, PHY_ADDR, ra, wd, rd);
    repeat (4) @(negedge clk);
  endtask : wr
  task automatic pulse(input logic [4:0] m);
    @(negedge clk);
    ev = m;
    @(negedge clk);
    ev = 5'h00;
  endtask : pulse
  task automatic wait_irq(input logic v);
    for (int n = 0; n < 12 && status_irq !== v; n++) @(negedge clk);
    `CHK("status_irq", v, status_irq)
    if (status_irq !== v) tally_and_finish();
  endtask : wait_irq
  task automatic tally_and_finish;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // read data watcher and clock
  // ----------------------------------------
  always @(posedge rd_done) begin
    if (exp_q.size() == 0) begin
      `CHK("spare read", 1'b0, 1'b1)
    end else begin
      exp_w = exp_q.pop_front();
      `CHK("rdata", exp_w, rd_word)
    end
  end
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    rst_n = 1'b0;
    {elt_pin, link_up, full_duplex, partner_pause, pol_rev, ev} = 10'h000;
    ten_powered = 1'b1;
    speed_100 = 1'b1;
    an_state = 3'h3;
    void'($urandom(13));
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    wait_irq(1'b1);
    `CHK("jabber_en", 1'b1, jabber_func_en)
    rdp(PHY_ADDR, REG_TEN_CTRL, TC_RESET);
    rdp(PHY_ADDR, REG_QSTAT, qs(4'h0, 1'b0, 2'h0, 3'h3, 3'h3));
    @(negedge clk);
    {full_duplex, partner_pause} = 2'($urandom);
    link_up = 1'b1;
    rdp(PHY_ADDR, REG_QSTAT, qs(4'h0, 1'b0, 2'h0, 3'h3, 3'h3));
    rdp(PHY_ADDR, REG_QSTAT, qs(4'h0, 1'b1, 2'h0, 3'h3, 3'h3));
    wait_irq(1'b0);
    pulse(5'h1E);
    wait_irq(1'b1);
    rdp(PHY_ADDR, REG_QSTAT, qs(4'hF, 1'b1, 2'h0, 3'h3, 3'h3));
    rdp(PHY_ADDR, REG_QSTAT, qs(4'h0, 1'b1, 2'h0, 3'h3, 3'h3));
    @(negedge clk);
    speed_100 = 1'b0;
    pulse(5'h1B);
    rdp(PHY_ADDR, REG_QSTAT, qs(4'h1, 1'b1, 2'h0, 3'h3, 3'h3));
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      an_state = 3'(i) ^ 3'h5;
      repeat (2) @(negedge clk);
    end
    rdp(PHY_ADDR, REG_QSTAT, qs(4'h0, 1'b1, 2'h0, 3'h0, 3'h7));
    rdp(PHY_ADDR, REG_QSTAT, qs(4'h0, 1'b1, 2'h0, 3'h2, 3'h2));
    wr(REG_QSTAT, 16'hFF40);
    pulse(5'h04);
    repeat (6) @(negedge clk);
    `CHK("irq_masked", 1'b0, status_irq)
    rdp(PHY_ADDR, REG_QSTAT, qs(4'h2, 1'b1, 2'h1, 3'h2, 3'h2));
    wr(REG_QSTAT, 16'h0080);
    pulse(5'h04);
    repeat (6) @(negedge clk);
    `CHK("irq_cfg", 1'b0, status_irq)
    link_up = 1'b0;
    wait_irq(1'b1);
    rdp(PHY_ADDR, REG_QSTAT, qs(4'h6, 1'b0, 2'h2, 3'h2, 3'h2));
    @(negedge clk);
    link_up = 1'b1;
    rdp(PHY_ADDR, REG_QSTAT, qs(4'h4, 1'b0, 2'h2, 3'h2, 3'h2));
    wr(REG_QSTAT, 16'h0000);
    wr(5'h05, 16'hA5A5);
    rdp(PHY_ADDR, 5'h05, 16'h0000);
    rdp(5'h11, REG_TEN_CTRL, 16'hFFFF);
    u_mdio_station.xfer(OP_WRITE, 5'h11, REG_TEN_CTRL, 16'hFFFF, rd);
    rdp(PHY_ADDR, REG_TEN_CTRL, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      w = (k == 0) ? 16'hFFFF : 16'($urandom);
      w[3] = (k == 0);
      wr(REG_TEN_CTRL, w);
      speed_100 = k[0];
      ten_powered = (k != 2);
      elt_pin = k[1];
      link_up = (k != 3);
      pol_rev = 1'b1;
      repeat (6) @(negedge clk);
      rdp(PHY_ADDR, REG_TEN_CTRL, w & TC_WMASK);
      `CHK("tone", w[15] & ten_powered, test_tone_on)
      `CHK("hold", w[14] & link_up, power_hold_on)
      `CHK("jab_en", ~w[13], jabber_func_en)
      `CHK("elt", w[6] | elt_pin, enhanced_link_test)
      `CHK("ten_only", {w[5], w[4], w[1], w[0]} & {4{~speed_100}}, ten_out)
      `CHK("pol", {~speed_100, ~speed_100 & ~w[3]}, {polarity_status, polarity_correct})
    end
    repeat (20) @(negedge clk);
    `CHK("pending", 32'h0, 32'(exp_q.size()))
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
